// file: core/mms_host.sv
// host end: APB registers, serial master, sideband pin control and interrupt
`timescale 1ns/1ps
`include "mms_map.svh"
module mms_host
    import mms_pkg::*;
#(
    parameter int QTR_CYC = `MMS_SCL_QTR_CYC
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    mms_link_if.host LINK
);
    localparam int NP = 3;
    if (QTR_CYC < 8 || QTR_CYC > 65535) begin : g_bad
        $error("mms_host: QTR_CYC out of range");
    end

    function automatic logic [7:0] tx_byte(input logic [1:0] i, input logic [7:0] off,
            input logic [7:0] wd, input logic rd);
        case (i)
            2'd0: return {`MMS_DEV_ADDR, `MMS_WR_BIT};
            2'd1: return off;
            2'd2: return rd ? {`MMS_DEV_ADDR, `MMS_RD_BIT} : wd;
            default: return 8'hff;
        endcase
    endfunction

    logic [NP-1:0] s1, s2, s3, lvl, lvl_d;
    wire [NP-1:0] raw = {LINK.interrupt_n, LINK.present_n, LINK.sda};
    genvar gi;
    for (gi = 0; gi < NP; gi++) begin : g_sync
        always_ff @(posedge REF_CLK or negedge RST_N) begin
            if (!RST_N) begin
                s1[gi] <= 1'b1;
                s2[gi] <= 1'b1;
                s3[gi] <= 1'b1;
                lvl[gi] <= 1'b1;
                lvl_d[gi] <= 1'b1;
            end else begin
                s1[gi] <= raw[gi];
                s2[gi] <= s1[gi];
                s3[gi] <= s2[gi];
                lvl[gi] <= (s2[gi] == s3[gi]) ? s2[gi] : lvl[gi];
                lvl_d[gi] <= lvl[gi];
            end
        end
    end
    wire sda = lvl[`MMS_HP_SDA];
    wire int_fall = !lvl[`MMS_HP_INT] && lvl_d[`MMS_HP_INT];
    wire prs_chg = lvl[`MMS_HP_PRS] != lvl_d[`MMS_HP_PRS];

    // APB slave with one wait state
    logic [2:0] ctrl;
    logic [7:0] c_off, c_wd;
    logic c_rd;
    logic [7:0] rdata;
    logic nack;
    logic ready;
    logic [`MMS_IRQ_W-1:0] irq_st, irq_en;
    mms_host_e hst;
    wire acc = PSEL && PENABLE && PREADY;
    wire wr = acc && PWRITE;
    wire go = wr && PADDR == `MMS_REG_CMD && hst == H_IDLE;
    wire mapped = PADDR == `MMS_REG_CTRL || PADDR == `MMS_REG_CMD || PADDR == `MMS_REG_STAT
        || PADDR == `MMS_REG_IRQ_STAT || PADDR == `MMS_REG_IRQ_CLR || PADDR == `MMS_REG_IRQ_EN;
    wire [31:0] stat = {19'h0, ready, !lvl[`MMS_HP_INT], !lvl[`MMS_HP_PRS], nack,
        hst != H_IDLE, rdata};
    wire [31:0] rd_mux = (PADDR == `MMS_REG_CTRL) ? {29'h0, ctrl} :
                         (PADDR == `MMS_REG_CMD) ? {15'h0, c_rd, c_wd, c_off} :
                         (PADDR == `MMS_REG_STAT) ? stat :
                         (PADDR == `MMS_REG_IRQ_STAT) ? 32'(irq_st) :
                         (PADDR == `MMS_REG_IRQ_EN) ? 32'(irq_en) : 32'h0;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PRDATA <= '0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL && PENABLE && !PREADY;
            if (PSEL && PENABLE && !PREADY) begin
                PRDATA <= PWRITE ? 32'h0 : rd_mux;
                PSLVERR <= !mapped;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl <= `MMS_CTRL_RST;
            irq_en <= '0;
            c_off <= '0;
            c_wd <= '0;
            c_rd <= 1'b0;
        end else begin
            if (wr && PADDR == `MMS_REG_CTRL) ctrl <= PWDATA[2:0];
            if (wr && PADDR == `MMS_REG_IRQ_EN) irq_en <= PWDATA[`MMS_IRQ_W-1:0];
            if (go) begin
                c_off <= PWDATA[7:0];
                c_wd <= PWDATA[15:8];
                c_rd <= PWDATA[`MMS_CMD_READ];
            end
        end
    end

    // serial master, four quarter ticks per bit
    logic [15:0] div;
    logic tick;
    logic [1:0] ph, idx;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic scl, sda_oe, done, nack_ev;
    wire rx = c_rd && idx == 2'd3;
    wire last = c_rd ? idx == 2'd3 : idx == 2'd2;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            div <= '0;
            tick <= 1'b0;
        end else begin
            tick <= hst != H_IDLE && div == 16'(QTR_CYC - 1);
            div <= (hst == H_IDLE || div == 16'(QTR_CYC - 1)) ? 16'h0 : div + 16'h1;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            hst <= H_IDLE;
            ph <= '0;
            idx <= '0;
            bitn <= '0;
            shift <= '0;
            scl <= 1'b1;
            sda_oe <= 1'b0;
            nack <= 1'b0;
            rdata <= '0;
            done <= 1'b0;
            nack_ev <= 1'b0;
        end else begin
            done <= 1'b0;
            nack_ev <= 1'b0;
            if (hst == H_IDLE) begin
                ph <= '0;
                if (go) begin
                    hst <= H_START;
                    idx <= '0;
                    bitn <= '0;
                    nack <= 1'b0;
                end
            end else if (tick) begin
                ph <= ph + 2'd1;
                case (hst)
                    H_START: begin
                        if (ph == 2'd0) sda_oe <= 1'b0;
                        if (ph == 2'd1) scl <= 1'b1;
                        if (ph == 2'd2) sda_oe <= 1'b1;
                        if (ph == 2'd3) begin
                            scl <= 1'b0;
                            shift <= tx_byte(idx, c_off, c_wd, c_rd);
                            hst <= H_BITS;
                        end
                    end
                    H_BITS: begin
                        if (ph == 2'd0) sda_oe <= bitn < 4'h8 && !rx && !shift[7];
                        if (ph == 2'd1) scl <= 1'b1;
                        if (ph == 2'd2 && bitn < 4'h8) shift <= {shift[6:0], sda};
                        if (ph == 2'd2 && bitn == 4'h8 && !rx && sda) begin
                            nack <= 1'b1;
                            nack_ev <= 1'b1;
                        end
                        if (ph == 2'd3) begin
                            scl <= 1'b0;
                            bitn <= bitn + 4'h1;
                            if (bitn == 4'h8) begin
                                bitn <= '0;
                                if (rx && !ready) rdata <= 8'h00;
                                else if (rx) rdata <= shift;
                                if (nack || last) begin
                                    hst <= H_STOP;
                                end else if (c_rd && idx == 2'd1) begin
                                    idx <= 2'd2;
                                    hst <= H_START;
                                end else begin
                                    idx <= idx + 2'd1;
                                    shift <= tx_byte(idx + 2'd1, c_off, c_wd, c_rd);
                                end
                            end
                        end
                    end
                    H_STOP: begin
                        if (ph == 2'd0) sda_oe <= 1'b1;
                        if (ph == 2'd1) scl <= 1'b1;
                        if (ph == 2'd2) sda_oe <= 1'b0;
                        if (ph == 2'd3) begin
                            hst <= H_IDLE;
                            done <= 1'b1;
                        end
                    end
                    default: hst <= H_IDLE;
                endcase
            end
        end
    end

    // module readiness: serial read data is returned as zero from reset, or while the module reset pin is low, until the module interrupt line falls
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) ready <= 1'b0;
        else if (!ctrl[`MMS_CTRL_RST_N]) ready <= 1'b0;
        else if (int_fall) ready <= 1'b1;
    end

    // interrupt status: 0 done, 1 nack, 2 module interrupt, 3 presence change
    wire [`MMS_IRQ_W-1:0] ev = {prs_chg, int_fall, nack_ev, done};
    wire [`MMS_IRQ_W-1:0] clr = (wr && PADDR == `MMS_REG_IRQ_CLR) ?
        PWDATA[`MMS_IRQ_W-1:0] : '0;
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_st <= '0;
            IRQ <= 1'b0;
        end else begin
            irq_st <= (irq_st & ~clr) | ev;
            IRQ <= |(irq_st & irq_en);
        end
    end

    assign LINK.scl = scl;
    assign LINK.host_sda_out = 1'b0;
    assign LINK.host_sda_oe = sda_oe;
    assign LINK.select_n = ctrl[`MMS_CTRL_SEL_N];
    assign LINK.reset_n = ctrl[`MMS_CTRL_RST_N];
    assign LINK.lp_req = ctrl[`MMS_CTRL_LP];
endmodule

// file: core/mms_map.svh
// address map, field positions and timing counts of the management sideband link
`ifndef MMS_MAP_SVH
`define MMS_MAP_SVH
`define MMS_CLK_MHZ 125
`define MMS_DEV_ADDR 7'h50
`define MMS_RD_BIT 1'b1
`define MMS_WR_BIT 1'b0
// module memory, lower page offsets
`define MMS_OFF_ID 7'h00
`define MMS_OFF_STATUS 7'h02
`define MMS_OFF_FLAGS 7'h03
`define MMS_OFF_FLAG_CLR 7'h04
`define MMS_OFF_MON_HI 7'h16
`define MMS_OFF_MON_LO 7'h17
`define MMS_OFF_CTRL 7'h56
`define MMS_CTRL_BYTES 12
`define MMS_OFF_MASK 7'h64
`define MMS_OFF_PAGE 7'h7f
`define MMS_MASK_RST 8'hff
`define MMS_NUM_PAGES 4
// timing
`define MMS_RESET_MIN_NS 10000
`define MMS_RESET_MIN_CYC ((`MMS_RESET_MIN_NS * `MMS_CLK_MHZ + 999) / 1000)
`define MMS_INIT_MS 2000
`define MMS_INIT_CYC (`MMS_INIT_MS * `MMS_CLK_MHZ * 1000)
`define MMS_SCL_QTR_NS 1250
`define MMS_SCL_QTR_CYC ((`MMS_SCL_QTR_NS * `MMS_CLK_MHZ) / 1000)
// device pin synchroniser slots
`define MMS_DP_SCL 0
`define MMS_DP_SDA 1
`define MMS_DP_SEL 2
`define MMS_DP_RST 3
`define MMS_DP_LP 4
// host pin synchroniser slots
`define MMS_HP_SDA 0
`define MMS_HP_PRS 1
`define MMS_HP_INT 2
// host register offsets (byte addresses)
`define MMS_REG_CTRL 12'h000
`define MMS_REG_CMD 12'h004
`define MMS_REG_STAT 12'h008
`define MMS_REG_IRQ_STAT 12'h00c
`define MMS_REG_IRQ_CLR 12'h010
`define MMS_REG_IRQ_EN 12'h014
// host register fields
`define MMS_CTRL_SEL_N 0
`define MMS_CTRL_RST_N 1
`define MMS_CTRL_LP 2
`define MMS_CTRL_RST 3'h3
`define MMS_CMD_READ 16
`define MMS_ST_BUSY 8
`define MMS_ST_NACK 9
`define MMS_ST_PRESENT 10
`define MMS_ST_INT 11
`define MMS_ST_READY 12
`define MMS_IRQ_W 4
`endif

// file: core/mms_pkg.sv
// types shared by both ends of the management sideband link
package mms_pkg;
    typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_OFFSET, SL_WRITE, SL_READ} mms_slave_e;
    typedef enum logic [1:0] {H_IDLE, H_START, H_BITS, H_STOP} mms_host_e;
endpackage

// file: core/mms_link_if.sv
// management sideband pins between host board and module
`timescale 1ns/1ps
interface mms_link_if;
    logic scl;
    logic host_sda_out;
    logic host_sda_oe;
    logic dev_sda_out;
    logic dev_sda_oe;
    logic sda;
    logic select_n;
    logic reset_n;
    logic lp_req;
    logic dev_present_out;
    logic dev_present_oe;
    logic present_n;
    logic dev_int_out;
    logic dev_int_oe;
    logic interrupt_n;
    // open-drain lines with pull-ups on the host board
    assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));
    assign present_n = !(dev_present_oe && !dev_present_out);
    assign interrupt_n = !(dev_int_oe && !dev_int_out);
    modport dev (input scl, sda, select_n, reset_n, lp_req,
        output dev_sda_out, dev_sda_oe, dev_present_out, dev_present_oe, dev_int_out, dev_int_oe);
    modport host (input sda, present_n, interrupt_n,
        output scl, host_sda_out, host_sda_oe, select_n, reset_n, lp_req);
endinterface

// file: core/mms_module.sv
// module end: select/reset/low-power pins, serial slave, paged memory, interrupt
`timescale 1ns/1ps
`include "mms_map.svh"
module mms_module
    import mms_pkg::*;
#(
    parameter int NUM_PAGES = `MMS_NUM_PAGES,
    parameter int INIT_CYC = `MMS_INIT_CYC,
    parameter int RESET_MIN_CYC = `MMS_RESET_MIN_CYC,
    parameter logic [7:0] ID_CODE = 8'h5a // arbitrary value
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic [6:0] EVENT,
    input wire logic [15:0] MONITOR,
    output logic LOW_POWER,
    output logic INIT_PENDING,
    output logic [8*`MMS_CTRL_BYTES-1:0] CONTROL,
    mms_link_if.dev LINK
);
    localparam int UW = $clog2(NUM_PAGES * 128);
    localparam int NP = 5;

    if (NUM_PAGES < 1 || NUM_PAGES > 256 || INIT_CYC < 1 || RESET_MIN_CYC < 1
            || RESET_MIN_CYC > 65534) begin : g_bad
        $error("mms_module: unsupported parameters");
    end

    function automatic logic is_ctrl(input logic [6:0] a);
        return a >= `MMS_OFF_CTRL && a < 7'(`MMS_OFF_CTRL + `MMS_CTRL_BYTES);
    endfunction

    // pin synchronisers: a change counts once stages two and three agree
    logic [NP-1:0] s1, s2, s3, lvl, lvl_d;
    wire [NP-1:0] raw = {LINK.lp_req, LINK.reset_n, LINK.select_n, LINK.sda, LINK.scl};
    genvar gi;
    for (gi = 0; gi < NP; gi++) begin : g_sync
        // start from the pin's idle level so no false change follows reset
        localparam logic IDLE_LVL = (gi == `MMS_DP_LP) ? 1'b0 : 1'b1;
        always_ff @(posedge REF_CLK or negedge RST_N) begin
            if (!RST_N) begin
                s1[gi] <= IDLE_LVL;
                s2[gi] <= IDLE_LVL;
                s3[gi] <= IDLE_LVL;
                lvl[gi] <= IDLE_LVL;
                lvl_d[gi] <= IDLE_LVL;
            end else begin
                s1[gi] <= raw[gi];
                s2[gi] <= s1[gi];
                s3[gi] <= s2[gi];
                lvl[gi] <= (s2[gi] == s3[gi]) ? s2[gi] : lvl[gi];
                lvl_d[gi] <= lvl[gi];
            end
        end
    end

    wire scl = lvl[`MMS_DP_SCL];
    wire sda = lvl[`MMS_DP_SDA];
    wire sel_n = lvl[`MMS_DP_SEL];
    wire rst_pin = lvl[`MMS_DP_RST];
    wire scl_rise = scl && !lvl_d[`MMS_DP_SCL];
    wire scl_fall = !scl && lvl_d[`MMS_DP_SCL];
    wire start = scl && lvl_d[`MMS_DP_SCL] && !sda && lvl_d[`MMS_DP_SDA];
    wire stop = scl && lvl_d[`MMS_DP_SCL] && sda && !lvl_d[`MMS_DP_SDA];

    // reset pulse length and initialisation timer
    logic [15:0] low_cnt;
    logic [31:0] init_cnt;
    logic done;
    wire soft_rst = !rst_pin && (low_cnt >= 16'(RESET_MIN_CYC));

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            low_cnt <= '0;
            init_cnt <= '0;
            INIT_PENDING <= 1'b1;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!rst_pin) begin
                if (!soft_rst) low_cnt <= low_cnt + 16'h0001;
                init_cnt <= '0;
                if (soft_rst) INIT_PENDING <= 1'b1;
            end else begin
                low_cnt <= '0;
                if (INIT_PENDING) begin
                    if (init_cnt == 32'(INIT_CYC - 1)) begin
                        INIT_PENDING <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        init_cnt <= init_cnt + 32'h1;
                    end
                end
            end
        end
    end

    // serial slave
    mms_slave_e sst;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic sda_oe;
    logic [7:0] page;
    logic [7:0] mask;
    logic [7:0] flags;
    logic [7:0] upper [NUM_PAGES * 128];
    logic [7:0] rdata;

    wire page_ok = 9'(page) < 9'(NUM_PAGES);
    wire [UW-1:0] uidx = UW'({page, ptr[6:0]});
    wire [6:0] la = ptr[6:0];
    wire [3:0] cidx = 4'(la - `MMS_OFF_CTRL);
    wire [7:0] ctrl_rd = CONTROL[8*cidx +: 8];
    wire [7:0] lo_rd = (la == `MMS_OFF_ID) ? ID_CODE :
                       (la == `MMS_OFF_STATUS) ? {7'h00, INIT_PENDING} :
                       (la == `MMS_OFF_FLAGS) ? flags :
                       (la == `MMS_OFF_MON_HI) ? MONITOR[15:8] :
                       (la == `MMS_OFF_MON_LO) ? MONITOR[7:0] :
                       is_ctrl(la) ? ctrl_rd :
                       (la == `MMS_OFF_MASK) ? mask :
                       (la == `MMS_OFF_PAGE) ? page : 8'h00;
    // lower half never depends on the page selector
    assign rdata = !ptr[7] ? lo_rd : (page_ok ? upper[uidx] : 8'h00);
    wire byte_end = scl_fall && bitcnt == 4'h8;
    wire wr_fire = !sel_n && byte_end && sst == SL_WRITE;
    wire addr_hit = shift[7:1] == `MMS_DEV_ADDR;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sst <= SL_IDLE;
            bitcnt <= '0;
            shift <= '0;
            ptr <= '0;
            sda_oe <= 1'b0;
        end else if (sel_n) begin
            sst <= SL_IDLE;
            bitcnt <= '0;
            sda_oe <= 1'b0;
        end else if (start) begin
            sst <= SL_ADDR;
            bitcnt <= '0;
            sda_oe <= 1'b0;
        end else if (stop) begin
            sst <= SL_IDLE;
            sda_oe <= 1'b0;
        end else if (sst != SL_IDLE && scl_rise) begin
            bitcnt <= bitcnt + 4'h1;
            if (bitcnt < 4'h8 && sst != SL_READ) shift <= {shift[6:0], sda};
            // master not-acknowledge ends a read
            if (bitcnt == 4'h8 && sst == SL_READ && sda) sst <= SL_IDLE;
        end else if (sst != SL_IDLE && scl_fall) begin
            if (bitcnt == 4'h8) begin
                sda_oe <= 1'b0;
                case (sst)
                    SL_ADDR: begin
                        if (addr_hit) begin
                            sda_oe <= 1'b1;
                            sst <= (shift[0] == `MMS_RD_BIT) ? SL_READ : SL_OFFSET;
                        end else begin
                            sst <= SL_IDLE;
                        end
                    end
                    SL_OFFSET: begin
                        ptr <= shift;
                        sda_oe <= 1'b1;
                        sst <= SL_WRITE;
                    end
                    SL_WRITE: begin
                        ptr <= ptr + 8'h01;
                        sda_oe <= 1'b1;
                    end
                    default: sda_oe <= 1'b0;
                endcase
            end else if (bitcnt == 4'h9) begin
                bitcnt <= '0;
                sda_oe <= 1'b0;
                if (sst == SL_READ) begin
                    shift <= rdata;
                    ptr <= ptr + 8'h01;
                    sda_oe <= !rdata[7];
                end
            end else if (sst == SL_READ) begin
                shift <= {shift[6:0], 1'b0};
                sda_oe <= !shift[6];
            end
        end
    end

    // writable settings; page, mask, control bytes and flags return to default on a long reset, upper page memory keeps its data
    wire [7:0] clr = (wr_fire && !ptr[7] && la == `MMS_OFF_FLAG_CLR) ? shift : 8'h00;
    wire [7:0] next_flags = (flags & ~clr) | {EVENT, done}; // set wins over clear

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            page <= '0;
            mask <= `MMS_MASK_RST;
            CONTROL <= '0;
            flags <= '0;
        end else if (soft_rst) begin
            page <= '0;
            mask <= `MMS_MASK_RST;
            CONTROL <= '0;
            flags <= '0;
        end else begin
            flags <= next_flags;
            if (wr_fire && !ptr[7] && la == `MMS_OFF_PAGE) page <= shift;
            if (wr_fire && !ptr[7] && la == `MMS_OFF_MASK) mask <= shift;
            if (wr_fire && !ptr[7] && is_ctrl(la)) CONTROL[8*cidx +: 8] <= shift;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (wr_fire && ptr[7] && page_ok) upper[uidx] <= shift;
    end

    // pins driven by the module
    logic int_oe;
    logic present_oe;
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            int_oe <= 1'b0;
            present_oe <= 1'b0;
            LOW_POWER <= 1'b0;
        end else begin
            int_oe <= !INIT_PENDING && |(flags & mask);
            present_oe <= 1'b1;
            LOW_POWER <= lvl[`MMS_DP_LP];
        end
    end

    assign LINK.dev_sda_out = 1'b0;
    assign LINK.dev_sda_oe = sda_oe;
    assign LINK.dev_int_out = 1'b0;
    assign LINK.dev_int_oe = int_oe;
    assign LINK.dev_present_out = 1'b0;
    assign LINK.dev_present_oe = present_oe;
endmodule

// file: bench/mms_link_monitor.sv
// assertions on the sideband pins between host and module ends
`timescale 1ns/1ps
module mms_link_monitor #(parameter int INIT_CYC = 200) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic scl,
    input wire logic select_n,
    input wire logic reset_n,
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe,
    input wire logic present_n,
    input wire logic dev_int_out,
    input wire logic dev_int_oe,
    input wire logic interrupt_n
);
    localparam int W_LO = INIT_CYC - 8;
    logic [5:0] low_cnt;
    // cycles the reset pin has been low, saturating
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            low_cnt <= 6'h00;
        end else if (reset_n) begin
            low_cnt <= 6'h00;
        end else if (low_cnt != 6'h3f) begin
            low_cnt <= low_cnt + 6'h01;
        end
    end
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);
    chk_desel_quiet: assert property (select_n [*6] |-> !dev_sda_oe)
        else $error("data line driven while deselected");
    chk_drain_only: assert property (dev_int_oe || dev_sda_oe |-> !dev_int_out && !dev_sda_out)
        else $error("open drain line driven high");
    chk_present_low: assert property ($past(RST_N) |-> !present_n)
        else $error("present line not low");
    chk_sda_steady: assert property (scl && $past(scl) && !select_n && !$past(select_n)
        |-> $stable(dev_sda_oe)) else $error("data changed while clock high");
    chk_rst_quiet: assert property (low_cnt >= 6'h20 |-> interrupt_n)
        else $error("interrupt during long reset");
    chk_init_wait: assert property (reset_n && low_cnt >= 6'h20 |->
        (interrupt_n throughout ##W_LO 1'b1) ##[1:30] !interrupt_n) else $error("bad init time");
    chk_powerup_irq: assert property ($rose(RST_N) |->
        (interrupt_n throughout ##W_LO 1'b1) ##[1:30] !interrupt_n) else $error("no power-up irq");
    chk_irq_sticky: assert property (!interrupt_n && select_n && reset_n |=> !interrupt_n)
        else $error("interrupt dropped while idle");
endmodule

// file: bench/tb.sv
// bench: host and module ends joined over the sideband link, driven over apb
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    checked++; \
    if ((g) !== (e)) begin \
        n_fail++; \
        $display("wrong value %s exp %h got %h", nm, e, g); \
    end \
end
module tb;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, low_power, init_pending, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0] event_in;
    logic [15:0] monitor;
    logic [95:0] control;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    mms_link_if link_if();
    mms_module #(.INIT_CYC(200), .RESET_MIN_CYC(20)) mms_module_inst (.REF_CLK(clk),
        .RST_N(rst_n), .EVENT(event_in), .MONITOR(monitor), .LOW_POWER(low_power),
        .INIT_PENDING(init_pending), .CONTROL(control), .LINK(link_if.dev));
    mms_host #(.QTR_CYC(8)) mms_host_inst (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .LINK(link_if.host));
    mms_link_monitor #(.INIT_CYC(200)) monitor_inst (.REF_CLK(clk), .RST_N(rst_n),
        .scl(link_if.scl), .select_n(link_if.select_n), .reset_n(link_if.reset_n),
        .dev_sda_out(link_if.dev_sda_out), .dev_sda_oe(link_if.dev_sda_oe),
        .present_n(link_if.present_n), .dev_int_out(link_if.dev_int_out),
        .dev_int_oe(link_if.dev_int_oe), .interrupt_n(link_if.interrupt_n));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one serial command, then poll status until the host is idle
    task automatic ser(input logic r, input logic [7:0] off, input logic [7:0] wd);
        apb(1'b1, 12'h004, {15'h0000, r, wd, off});
        rd = 32'h100;
        while (rd[8] !== 1'b0) begin
            apb(1'b0, 12'h008, 32'h0);
        end
    endtask
    // poll until the host reports the module ready
    task automatic wait_int();
        rd = 32'h0;
        while (rd[12] !== 1'b1) begin
            apb(1'b0, 12'h008, 32'h0);
        end
    endtask
    task automatic t_power();
        wait_int();
        `CHK("present", 1'b1, rd[10])
        `CHK("line low", 1'b1, rd[11])
        apb(1'b1, 12'h014, 32'h6);
        repeat (2) @(posedge clk);
        `CHK("irq raised", 1'b1, irq)
    endtask
    task automatic t_flags();
        apb(1'b1, 12'h000, 32'h2);
        ser(1'b1, 8'h00, 8'h00);
        `CHK("id", 8'h5a, rd[7:0])
        `CHK("ack", 1'b0, rd[9])
        ser(1'b1, 8'h03, 8'h00);
        `CHK("done flag", 8'h01, rd[7:0])
        ser(1'b0, 8'h04, 8'h01);
        ser(1'b1, 8'h03, 8'h00);
        `CHK("flag cleared", 8'h00, rd[7:0])
        `CHK("line released", 1'b0, rd[11])
    endtask
    task automatic t_event();
        event_in <= 7'h04;
        @(posedge clk);
        event_in <= 7'h00;
        ser(1'b1, 8'h03, 8'h00);
        `CHK("event flag", 8'h08, rd[7:0])
        `CHK("event line", 1'b1, rd[11])
        ser(1'b0, 8'h04, 8'h08);
    endtask
    task automatic t_page();
        ser(1'b0, 8'h7f, 8'h01);
        ser(1'b0, 8'h80, 8'ha5);
        ser(1'b0, 8'h7f, 8'h02);
        ser(1'b0, 8'h80, 8'h3c);
        ser(1'b1, 8'h80, 8'h00);
        `CHK("page two", 8'h3c, rd[7:0])
        ser(1'b1, 8'h16, 8'h00);
        `CHK("monitor", 8'h12, rd[7:0])
        ser(1'b0, 8'h7f, 8'h01);
        ser(1'b1, 8'h80, 8'h00);
        `CHK("page one", 8'ha5, rd[7:0])
    endtask
    task automatic t_reset();
        ser(1'b0, 8'h56, 8'h3c);
        `CHK("control", 8'h3c, control[7:0])
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h000, 32'h2);
        repeat (10) @(posedge clk);
        `CHK("short pulse", 8'h3c, control[7:0])
        apb(1'b1, 12'h000, 32'h0);
        repeat (40) @(posedge clk);
        `CHK("defaults", 8'h00, control[7:0])
        `CHK("pending", 1'b1, init_pending)
        apb(1'b1, 12'h000, 32'h2);
        repeat (150) @(posedge clk);
        `CHK("from release", 1'b1, init_pending)
        wait_int();
        `CHK("init over", 1'b0, init_pending)
    endtask
    task automatic t_low();
        apb(1'b1, 12'h000, 32'h7);
        apb(1'b1, 12'h010, 32'hf);
        repeat (10) @(posedge clk);
        `CHK("low power", 1'b1, low_power)
        `CHK("irq cleared", 1'b0, irq)
        ser(1'b1, 8'h00, 8'h00);
        `CHK("deselected", 1'b1, rd[9])
        repeat (2) @(posedge clk);
        `CHK("nack irq", 1'b1, irq)
        apb(1'b1, 12'h014, 32'h0);
        repeat (2) @(posedge clk);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b0, 12'h020, 32'h0);
        `CHK("unmapped", 1'b1, er)
    endtask
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        event_in = 7'h00;
        monitor = 16'h1234;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_power();
        t_flags();
        t_event();
        t_page();
        t_reset();
        t_low();
        conclude();
    end
endmodule
